// [rtl/tos_defines.vh]
/*
  Constants for the thermal overload supervisor: encodings, defaults, timing.
  Assumes a 125 MHz reference clock and a one-cycle program tick from outside.
*/
// Notes on behaviour
// - Alarm, inhibit and trip decisions come from comparing thermal capacity against configured thresholds.
// - Alarm 1 asserts while enabled and capacity reaches its level, default 40 percent.
// - Alarm 2 asserts while enabled and capacity reaches its own level, default 40 percent.
// - Restart inhibit asserts while enabled and capacity reaches inhibit level, default 80 percent.
// - Trip decision asserts while enabled and capacity reaches trip level, default 100 percent.
// - Blocking input is sampled once at the start of every program cycle.
// - Pick-up without blocking raises start and proceeds to operate timing.
// - Pick-up with blocking raises blocked and does no further operate processing.
// - Start active when blocking arrives clears start and releases as on drop-out.
// - Threshold and delay settings may change while running without stopping.
// - Five behaviour modes: on, blocked, test, test-and-blocked, off.
// - Condition reports normal, alarm 1, alarm 2, inhibit, trip or blocked.
// - Load status: light, normal, overloading or high overload by current and trip pick-up.
// - Invalid service factor uses 1.0 and flags a fault while it exists.
// - Inconsistent ambient settings use factor 1.0 and flag a fault while present.
// - Resettable counters count alarm, inhibit, trip and blocked activations.
`ifndef TOS_DEFINES_VH
`define TOS_DEFINES_VH
// Levels in 0.1 percent units
`define TOS_LVL_W 11
`define TOS_ALARM1_DEF 11'h190
`define TOS_ALARM2_DEF 11'h190
`define TOS_INHIBIT_DEF 11'h320
`define TOS_TRIP_DEF 11'h3e8
// Trip delay in 5 ms steps, 0..720000 steps
`define TOS_DLY_W 20
`define TOS_DLY_STEP_US 5000
`define TOS_CLK_MHZ 125
`define TOS_STEP_CYC (`TOS_DLY_STEP_US * `TOS_CLK_MHZ)
// Behaviour modes
`define TOS_MODE_ON 3'h0
`define TOS_MODE_BLK 3'h1
`define TOS_MODE_TEST 3'h2
`define TOS_MODE_TBLK 3'h3
`define TOS_MODE_OFF 3'h4
// Condition codes
`define TOS_CND_NORMAL 3'h0
`define TOS_CND_ALARM1 3'h1
`define TOS_CND_ALARM2 3'h2
`define TOS_CND_INHIBIT 3'h3
`define TOS_CND_TRIP 3'h4
`define TOS_CND_BLOCKED 3'h5
// Load status codes
`define TOS_LOAD_LIGHT 2'h0
`define TOS_LOAD_NORMAL 2'h1
`define TOS_LOAD_OVER 2'h2
`define TOS_LOAD_HIGH 2'h3
// Current in 0.01 x nominal units
`define TOS_CUR_W 12
`define TOS_CUR_LIGHT 12'h001
`define TOS_CUR_HIGH 12'h0c8
`define TOS_SF_ONE 12'h064
`define TOS_KAMB_ONE 12'h064
`define TOS_CNT_W 16
`endif

// [rtl/tos_supervisor.v]
/*
  Output decision logic of the thermal overload stage: thresholds, trip delay,
  blocking, mode, condition, load status, setting faults and counters.
  Assumes capacity and current come from the thermal image on ref_clk_i, the
  program tick is a one-cycle pulse on ref_clk_i, and the blocking input is async.
  Settings and enables come from logic on ref_clk_i and are used as they stand;
  only the blocking input is resynchronised before use.
*/
`include "tos_defines.vh"
module tos_supervisor #(
  parameter LW = `TOS_LVL_W,
  parameter DW = `TOS_DLY_W,
  parameter CW = `TOS_CNT_W,
  parameter [31:0] STEP_CYC = `TOS_STEP_CYC
)(
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire prog_tick_i,
  input wire [LW-1:0] capacity_i,
  input wire [`TOS_CUR_W-1:0] current_i,
  input wire block_i,
  input wire [2:0] mode_i,
  input wire alarm1_en_i,
  input wire [LW-1:0] alarm1_lvl_i,
  input wire alarm2_en_i,
  input wire [LW-1:0] alarm2_lvl_i,
  input wire inhibit_en_i,
  input wire [LW-1:0] inhibit_lvl_i,
  input wire trip_en_i,
  input wire [LW-1:0] trip_lvl_i,
  input wire [DW-1:0] trip_dly_i,
  input wire [`TOS_CUR_W-1:0] service_factor_i,
  input wire sf_valid_i,
  input wire amb_consistent_i,
  input wire [`TOS_CUR_W-1:0] kamb_i,
  input wire cnt_clr_i,
  output reg alarm1_o,
  output reg alarm2_o,
  output reg inhibit_o,
  output reg trip_o,
  output reg start_o,
  output reg blocked_o,
  output reg [2:0] condition_o,
  output reg [1:0] load_o,
  output reg sf_fault_o,
  output reg amb_fault_o,
  output reg [`TOS_CUR_W-1:0] sf_used_o,
  output reg [`TOS_CUR_W-1:0] kamb_used_o,
  output reg [CW-1:0] alarm1_cnt_o,
  output reg [CW-1:0] alarm2_cnt_o,
  output reg [CW-1:0] inhibit_cnt_o,
  output reg [CW-1:0] trip_cnt_o,
  output reg [CW-1:0] blocked_cnt_o
);

  // ==========================================================
  // Blocking input synchroniser and program-cycle sample
  reg blk_s1;
  reg blk_s2;
  reg blk_smp;
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
    end
    else
    begin
      // Two flops against metastability on the async pin
      blk_s1 <= block_i;
      blk_s2 <= blk_s1;
    end
  end

  // Program-cycle sample of the synchronised blocking level
  // Blocking changes act only from the start of a program cycle
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      blk_smp <= 1'b0;
    else if (prog_tick_i)
      blk_smp <= blk_s2;
  end

  // ==========================================================
  // Mode decoding
  wire mode_off = (mode_i == `TOS_MODE_OFF);
  wire mode_blk = (mode_i == `TOS_MODE_BLK) || (mode_i == `TOS_MODE_TBLK);
  // Test modes act as on and blocked; codes above off act as on
  wire blocking = blk_smp | mode_blk;

  // ==========================================================
  // Threshold comparisons, live settings taken each cycle
  wire act = !mode_off;
  wire a1_hit = act && alarm1_en_i && (capacity_i >= alarm1_lvl_i);
  wire a2_hit = act && alarm2_en_i && (capacity_i >= alarm2_lvl_i);
  wire ih_hit = act && inhibit_en_i && (capacity_i >= inhibit_lvl_i);
  wire tp_hit = act && trip_en_i && (capacity_i >= trip_lvl_i);

  // ==========================================================
  // Level outputs gated off by any blocking
  wire next_a1 = a1_hit && !blocking;
  wire next_a2 = a2_hit && !blocking;
  wire next_ih = ih_hit && !blocking;

  // ==========================================================
  // Trip delay timer, cycles within a step and step count
  reg [31:0] sub_cnt;
  reg [DW-1:0] step_cnt;
  wire dly_done = (step_cnt >= trip_dly_i);
  wire run_timer = start_o && tp_hit;
  wire step_wrap = (sub_cnt >= STEP_CYC - 32'h1);
  // Held at zero while idle so each pick-up starts a full delay
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sub_cnt <= 32'h0;
      step_cnt <= {DW{1'b0}};
    end
    else if (!run_timer)
    begin
      sub_cnt <= 32'h0;
      step_cnt <= {DW{1'b0}};
    end
    else if (!dly_done)
    begin
      if (step_wrap)
      begin
        sub_cnt <= 32'h0;
        step_cnt <= step_cnt + {{(DW-1){1'b0}}, 1'b1};
      end
      else
        sub_cnt <= sub_cnt + 32'h1;
    end
  end

  // ==========================================================
  // Start, blocked and decision outputs
  wire pick = tp_hit;
  wire next_start = pick && !blocking;
  wire next_blocked = pick && blocking;
  wire next_trip = next_start && start_o && dly_done;
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      start_o <= 1'b0;
      blocked_o <= 1'b0;
      trip_o <= 1'b0;
    end
    else
    begin
      start_o <= next_start;
      blocked_o <= next_blocked;
      trip_o <= next_trip;
    end
  end

  // Alarm and inhibit levels
  // Each drops the cycle after its cause goes away
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      alarm1_o <= 1'b0;
      alarm2_o <= 1'b0;
      inhibit_o <= 1'b0;
    end
    else
    begin
      alarm1_o <= next_a1;
      alarm2_o <= next_a2;
      inhibit_o <= next_ih;
    end
  end

  // ==========================================================
  // Condition, load status, setting faults
  // Blocked outranks trip, so a blocked pick-up never shows trip
  reg [2:0] next_cond;
  reg [1:0] next_load;
  always @*
  begin
    next_cond = `TOS_CND_NORMAL;
    if (next_blocked)
      next_cond = `TOS_CND_BLOCKED;
    else if (next_trip)
      next_cond = `TOS_CND_TRIP;
    else if (ih_hit && !blocking)
      next_cond = `TOS_CND_INHIBIT;
    else if (a2_hit && !blocking)
      next_cond = `TOS_CND_ALARM2;
    else if (a1_hit && !blocking)
      next_cond = `TOS_CND_ALARM1;
  end

  // Load status from current and trip pick-up
  // Overloading means trip level reached at or below twice nominal
  always @*
  begin
    next_load = `TOS_LOAD_NORMAL;
    if (current_i < `TOS_CUR_LIGHT)
      next_load = `TOS_LOAD_LIGHT;
    else if (current_i > `TOS_CUR_HIGH)
      next_load = `TOS_LOAD_HIGH;
    else if (tp_hit)
      next_load = `TOS_LOAD_OVER;
  end

  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      condition_o <= `TOS_CND_NORMAL;
      load_o <= `TOS_LOAD_LIGHT;
    end
    else
    begin
      condition_o <= next_cond;
      load_o <= next_load;
    end
  end

  // Setting faults and the values actually used
  // Flags follow the settings, so they show only while wrong
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sf_fault_o <= 1'b0;
      amb_fault_o <= 1'b0;
      sf_used_o <= `TOS_SF_ONE;
      kamb_used_o <= `TOS_KAMB_ONE;
    end
    else
    begin
      sf_fault_o <= !sf_valid_i;
      sf_used_o <= sf_valid_i ? service_factor_i : `TOS_SF_ONE;
      amb_fault_o <= !amb_consistent_i;
      kamb_used_o <= amb_consistent_i ? kamb_i : `TOS_KAMB_ONE;
    end
  end

  // ==========================================================
  // Activation counters on rising edges of each output
  // Clear is a level; an activation in the same cycle still counts
  wire [CW-1:0] one = {{(CW-1){1'b0}}, 1'b1};

  // Alarm 1 activations
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      alarm1_cnt_o <= {CW{1'b0}};
    else if (next_a1 && !alarm1_o)
      alarm1_cnt_o <= cnt_clr_i ? one : alarm1_cnt_o + one;
    else if (cnt_clr_i)
      alarm1_cnt_o <= {CW{1'b0}};
  end

  // Alarm 2 activations
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      alarm2_cnt_o <= {CW{1'b0}};
    else if (next_a2 && !alarm2_o)
      alarm2_cnt_o <= cnt_clr_i ? one : alarm2_cnt_o + one;
    else if (cnt_clr_i)
      alarm2_cnt_o <= {CW{1'b0}};
  end

  // Restart inhibit activations
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      inhibit_cnt_o <= {CW{1'b0}};
    else if (next_ih && !inhibit_o)
      inhibit_cnt_o <= cnt_clr_i ? one : inhibit_cnt_o + one;
    else if (cnt_clr_i)
      inhibit_cnt_o <= {CW{1'b0}};
  end

  // Trip activations
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      trip_cnt_o <= {CW{1'b0}};
    else if (next_trip && !trip_o)
      trip_cnt_o <= cnt_clr_i ? one : trip_cnt_o + one;
    else if (cnt_clr_i)
      trip_cnt_o <= {CW{1'b0}};
  end

  // Blocked activations
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      blocked_cnt_o <= {CW{1'b0}};
    else if (next_blocked && !blocked_o)
      blocked_cnt_o <= cnt_clr_i ? one : blocked_cnt_o + one;
    else if (cnt_clr_i)
      blocked_cnt_o <= {CW{1'b0}};
  end

endmodule

// [test/tos_supervisor_assertions.sv]
/*
  Port checker for tos_supervisor, bound into every instance.
  Assumes the defines header and one clock with async active-low reset.
*/
`include "tos_defines.vh"
module tos_chk (
  input logic ref_clk_i,
  input logic arst_n_i,
  input logic [10:0] capacity_i,
  input logic [2:0] mode_i,
  input logic alarm1_en_i,
  input logic [10:0] alarm1_lvl_i,
  input logic inhibit_en_i,
  input logic [10:0] inhibit_lvl_i,
  input logic [11:0] current_i,
  input logic sf_valid_i,
  input logic alarm1_o,
  input logic inhibit_o,
  input logic trip_o,
  input logic start_o,
  input logic blocked_o,
  input logic [2:0] condition_o,
  input logic [1:0] load_o,
  input logic sf_fault_o,
  input logic [11:0] sf_used_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================
  // Output relations
  al1_gate_a: assert property (alarm1_o |-> $past(alarm1_en_i && capacity_i >= alarm1_lvl_i))
    else $error("alarm 1 without cause");
  inh_gate_a: assert property (inhibit_o |-> $past(inhibit_en_i && capacity_i >= inhibit_lvl_i))
    else $error("inhibit without cause");
  off_quiet_a: assert property ($past(mode_i) == `TOS_MODE_OFF |-> !alarm1_o && !trip_o && !start_o)
    else $error("output while off");
  normal_idle_a: assert property (condition_o == `TOS_CND_NORMAL |-> !(alarm1_o | inhibit_o | trip_o))
    else $error("output in normal condition");
  blk_excl_a: assert property (blocked_o |-> !start_o && !trip_o)
    else $error("start or trip while blocked");
  trip_start_a: assert property ($rose(trip_o) |-> $past(start_o))
    else $error("trip without start");
  sf_fault_a: assert property (!$past(sf_valid_i) |-> sf_fault_o && sf_used_o == `TOS_SF_ONE)
    else $error("service factor fault not shown");
  load_high_a: assert property ($past(current_i) > `TOS_CUR_HIGH |-> load_o == `TOS_LOAD_HIGH)
    else $error("high overload not shown");
  // Main scenarios reached
  cover property ($rose(trip_o));
  cover property ($rose(blocked_o));
  cover property ($rose(sf_fault_o));
endmodule
bind tos_supervisor tos_chk u_chk (.*);

// [test/test_thermal_overload_supervisor.sv]
/*
  Self-checking bench for tos_supervisor: random thresholds, trip delay, blocking.
  Assumes the design and its checker are compiled before this file.
*/
`include "tos_defines.vh"
module test_thermal_overload_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 4;
  logic ref_clk_i = 0, arst_n_i = 0, prog_tick_i = 0, block_i = 0, cnt_clr_i = 0, trip_en_i = 0;
  logic sf_valid_i = 1, amb_consistent_i = 1, alarm1_en_i = 0, alarm2_en_i = 0, inhibit_en_i = 0;
  logic [2:0] mode_i = 0;
  logic [10:0] capacity_i = 0, alarm1_lvl_i = 0, alarm2_lvl_i = 0, inhibit_lvl_i = 0;
  logic [10:0] trip_lvl_i = 11'h7ff;
  logic [11:0] current_i = 0, service_factor_i = 0, kamb_i = 0;
  logic [19:0] trip_dly_i = 0;
  logic alarm1_o, alarm2_o, inhibit_o, trip_o, start_o, blocked_o, sf_fault_o, amb_fault_o;
  logic [2:0] condition_o;
  logic [1:0] load_o;
  logic [11:0] sf_used_o, kamb_used_o;
  logic [15:0] alarm1_cnt_o, alarm2_cnt_o, inhibit_cnt_o, trip_cnt_o, blocked_cnt_o;
  logic [15:0] lf = 16'h004f;
  logic q, e1, e2, eh;
  logic p1 = 0, p2 = 0, ph = 0;
  int c1 = 0, c2 = 0, ch = 0;
  int bad_count = 0, checked = 0, n;
  tos_supervisor #(.STEP_CYC(S)) u_dut (.*);
  // Clock
  always #4 ref_clk_i = ~ref_clk_i;
  // ==========================================
  // Helpers
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [1:0] exp_load(input logic [11:0] c);
    return c < `TOS_CUR_LIGHT ? `TOS_LOAD_LIGHT : c > `TOS_CUR_HIGH ? `TOS_LOAD_HIGH : `TOS_LOAD_NORMAL;
  endfunction
  function automatic logic [2:0] exp_cnd(input logic a1, a2, ih);
    return ih ? `TOS_CND_INHIBIT : a2 ? `TOS_CND_ALARM2 : a1 ? `TOS_CND_ALARM1 : `TOS_CND_NORMAL;
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_for(ref logic s);
    n = 0;
    while (s !== 1'b1)
    begin
      @(negedge ref_clk_i);
      n++;
      if (n > 300)
      begin
        bad_count++;
        stop_test();
      end
    end
  endtask
  task tick;
    repeat (3) @(negedge ref_clk_i);
    prog_tick_i = 1;
    @(negedge ref_clk_i);
    prog_tick_i = 0;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (5) @(negedge ref_clk_i);
    arst_n_i = 1;
    for (int i = 0; i < 300; i++)
    begin
      lf = nxt(lf);
      capacity_i = {1'b0, lf[9:0]};
      lf = nxt(lf);
      alarm1_lvl_i = (i % 5 == 0) ? capacity_i : {1'b0, lf[9:0]};
      {alarm1_en_i, alarm2_en_i, inhibit_en_i, sf_valid_i, amb_consistent_i} = lf[15:11];
      lf = nxt(lf);
      alarm2_lvl_i = {1'b0, lf[9:0]};
      current_i = (i % 3 == 0) ? {11'h000, lf[10]} : (i % 3 == 1) ? 12'h0c8 + lf[11] : lf[15:10];
      lf = nxt(lf);
      inhibit_lvl_i = {1'b0, lf[9:0]};
      service_factor_i = lf[11:0];
      kamb_i = lf[15:4];
      mode_i = 3'(lf[14:12] % 5);
      @(negedge ref_clk_i);
      q = mode_i == `TOS_MODE_ON || mode_i == `TOS_MODE_TEST;
      e1 = q && alarm1_en_i && capacity_i >= alarm1_lvl_i;
      e2 = q && alarm2_en_i && capacity_i >= alarm2_lvl_i;
      eh = q && inhibit_en_i && capacity_i >= inhibit_lvl_i;
      chk(alarm1_o, e1);
      chk(alarm2_o, e2);
      chk(inhibit_o, eh);
      chk(condition_o, exp_cnd(e1, e2, eh));
      chk(load_o, exp_load(current_i));
      chk(sf_used_o, sf_valid_i ? service_factor_i : `TOS_SF_ONE);
      chk(kamb_used_o, amb_consistent_i ? kamb_i : `TOS_KAMB_ONE);
      chk(amb_fault_o, !amb_consistent_i);
      c1 += int'(e1 && !p1);
      c2 += int'(e2 && !p2);
      ch += int'(eh && !ph);
      {p1, p2, ph} = {e1, e2, eh};
      chk(alarm1_cnt_o, 16'(c1));
      chk(alarm2_cnt_o, 16'(c2));
      chk(inhibit_cnt_o, 16'(ch));
    end
    // Trip delay sweep after a counter clear
    {mode_i, alarm1_en_i, alarm2_en_i, inhibit_en_i, trip_en_i} = 7'h01;
    trip_lvl_i = `TOS_TRIP_DEF;
    cnt_clr_i = 1;
    @(negedge ref_clk_i);
    cnt_clr_i = 0;
    chk(trip_cnt_o, 0);
    for (int d = 0; d < 3; d++)
    begin
      trip_dly_i = 20'(d);
      capacity_i = `TOS_TRIP_DEF;
      wait_for(trip_o);
      chk(16'(n), 16'(2 + S * d));
      chk(trip_cnt_o, 16'(d + 1));
      chk(condition_o, `TOS_CND_TRIP);
      capacity_i = 11'h3e7;
      @(negedge ref_clk_i);
      chk({trip_o, start_o}, 0);
    end
    // Blocking of a running start, then release
    trip_dly_i = 20'd100;
    capacity_i = `TOS_TRIP_DEF;
    wait_for(start_o);
    block_i = 1;
    tick();
    wait_for(blocked_o);
    chk({start_o, trip_o}, 0);
    chk(blocked_cnt_o, 1);
    capacity_i = 0;
    repeat (2) @(negedge ref_clk_i);
    chk(blocked_o, 0);
    capacity_i = `TOS_TRIP_DEF;
    repeat (2) @(negedge ref_clk_i);
    chk({blocked_o, start_o}, 2);
    block_i = 0;
    tick();
    wait_for(start_o);
    chk(blocked_o, 0);
    trip_lvl_i = 11'h3e9;
    @(negedge ref_clk_i);
    chk(start_o, 0);
    stop_test();
  end
endmodule
